// file: logic/sbsp_defines.svh
// Widths, reset values and constants of the burst SRAM port control
`ifndef SBSP_DEFINES_SVH
`define SBSP_DEFINES_SVH

`define SBSP_ADDR_W   20
`define SBSP_DATA_W   36
`define SBSP_LANES    4
`define SBSP_LANE_W   9
`define SBSP_CNT_W    2

`define SBSP_ADDR_RST 20'h00000
`define SBSP_DATA_RST 36'h000000000
`define SBSP_CNT_RST  2'h0
`define SBSP_CNT_ONE  2'h1
`define SBSP_WE_NONE  4'h0
`define SBSP_WE_ALL   4'hF

`endif

// file: logic/sbsp_pkg.sv
// Types shared by the burst SRAM port control
package sbsp_pkg;

	// Selection state, loaded only on address cycles
	typedef enum logic [0:0] {
		SBSP_DESEL = 1'b0,
		SBSP_SEL   = 1'b1
	} sbsp_sel_t;

	// Burst order taken from the strap
	typedef enum logic [0:0] {
		SBSP_LINEAR     = 1'b0,
		SBSP_INTERLEAVE = 1'b1
	} sbsp_order_t;

endpackage : sbsp_pkg

// file: logic/sbsp_port_ctrl.sv
// Synchronous control front end of a pipelined burst SRAM
`timescale 1ns/1ns
`include "sbsp_defines.svh"

// Functional notes
// [R1] Capture address on strobe with valid selects
// [R2] Captured low two bits seed burst counter
// [R3] Lane write needs lane select and qualifier
// [R4] All-byte strobe writes every lane
// [R5] All inputs except output enable sampled on rising clock only
// [R6] Burst advance low steps counter, else hold
// [R7] Processor strobe ignored while first select high
// [R8] Selected only for low, high, low selects
// [R9] Chip selects sampled only on address loads
// [R10] Ball-grid variant treats third select active
// [R11] Output enable low drives data, high tristates
// [R12] Output enable acts without waiting for clock
// [R13] First read clock after deselect stays undriven
// [R14] Both strobes low: processor strobe wins
// [R15] Controller holds qualifier low for lane writes
// [R16] Strap: low linear, high interleaved, static
// [R17] Tristate on writes, after deselect, when deselected
// [R18] Linear adds count, interleaved XORs count
// [R19] Write data with write controls, enable high
module sbsp_port_ctrl (
	// Clock, reset, clock enable
	input  wire logic                        CLK,
	input  wire logic                        RST,
	input  wire logic                        CE,
	// Address and strobes
	input  wire logic [`SBSP_ADDR_W-1:0]     ADDR_IN,
	input  wire logic                        PROCESSOR_ADDRESS_STROBE_N,
	input  wire logic                        CONTROLLER_ADDRESS_STROBE_N,
	input  wire logic                        BURST_ADVANCE_N,
	// Chip selects and package variant
	input  wire logic                        CHIP_SELECT_FIRST_LOW_N,
	input  wire logic                        CHIP_SELECT_SECOND_HIGH,
	input  wire logic                        CHIP_SELECT_THIRD_LOW_N,
	input  wire logic                        BALL_GRID_PACKAGE,
	// Write controls
	input  wire logic [`SBSP_LANES-1:0]      BYTE_LANE_WRITE_SELECTS_N,
	input  wire logic                        BYTE_WRITE_QUALIFIER_N,
	input  wire logic                        ALL_BYTE_WRITE_STROBE_N,
	// Burst order strap, output drive enable
	input  wire logic                        BURST_ORDER_SEL,
	input  wire logic                        OUTPUT_DRIVE_ENABLE_N,
	// Data pins, split three ways
	input  wire logic [`SBSP_DATA_W-1:0]     DQ_IN,
	output logic      [`SBSP_DATA_W-1:0]     DQ_OUT,
	output logic                             DQ_OE_N,
	// Memory array side
	input  wire logic [`SBSP_DATA_W-1:0]     MEM_RDATA,
	output logic      [`SBSP_ADDR_W-1:0]     MEM_ADDR,
	output logic      [`SBSP_LANES-1:0]      MEM_WE,
	output logic      [`SBSP_DATA_W-1:0]     MEM_WDATA
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	sbsp_pkg::sbsp_sel_t           sel;
	sbsp_pkg::sbsp_sel_t           next_sel;
	sbsp_pkg::sbsp_order_t         order;
	logic [`SBSP_ADDR_W-1:0]       base;
	logic [`SBSP_ADDR_W-1:0]       next_base;
	logic [`SBSP_CNT_W-1:0]        cnt;
	logic [`SBSP_CNT_W-1:0]        next_cnt;
	logic [`SBSP_LANES-1:0]        next_we;
	logic                          drive_block;
	logic                          next_block;
	logic                          sel_now;
	logic                          ps_take;
	logic                          load;
	logic                          wr_cycle;

	// ------------------------------------------------------------
	// Burst sequence
	// ------------------------------------------------------------
	function automatic logic [`SBSP_CNT_W-1:0] burst_low(
		input sbsp_pkg::sbsp_order_t  ord,
		input logic [`SBSP_CNT_W-1:0] seed,
		input logic [`SBSP_CNT_W-1:0] step
	);
		if (ord == sbsp_pkg::SBSP_INTERLEAVE) begin
			burst_low = seed ^ step;
		end else begin
			burst_low = seed + step;
		end
	endfunction

	// ------------------------------------------------------------
	// Address cycle decode
	// ------------------------------------------------------------
	// Third select is not bonded out on the ball-grid variant
	assign sel_now = !CHIP_SELECT_FIRST_LOW_N & CHIP_SELECT_SECOND_HIGH &
		(BALL_GRID_PACKAGE | !CHIP_SELECT_THIRD_LOW_N); // [R8] [R10]

	// Processor strobe only counts with the first select low
	assign ps_take = !PROCESSOR_ADDRESS_STROBE_N & !CHIP_SELECT_FIRST_LOW_N; // [R7]

	// Controller strobe also loads, but loses to a taken processor strobe
	assign load = ps_take | !CONTROLLER_ADDRESS_STROBE_N; // [R1] [R14]

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_sel  = sel;
		next_base = base;
		next_cnt  = cnt;
		if (load) begin
			// Selects set the selection here only; the first select also gates ps_take
			next_sel = sel_now ? sbsp_pkg::SBSP_SEL : sbsp_pkg::SBSP_DESEL; // [R9]
			if (sel_now) begin
				next_base = ADDR_IN; // [R1]
				next_cnt  = `SBSP_CNT_RST; // [R2]
			end
		end else if (sel == sbsp_pkg::SBSP_SEL && !BURST_ADVANCE_N) begin
			next_cnt = cnt + `SBSP_CNT_ONE; // [R6]
		end
	end

	// A processor-strobe start is always a read start; write
	// controls on that edge are disregarded
	assign wr_cycle = !ps_take && next_sel == sbsp_pkg::SBSP_SEL; // [R14]

	always_comb begin
		if (!wr_cycle) begin
			next_we = `SBSP_WE_NONE;
		end else if (!ALL_BYTE_WRITE_STROBE_N) begin
			next_we = `SBSP_WE_ALL; // [R4]
		end else if (!BYTE_WRITE_QUALIFIER_N) begin
			next_we = ~BYTE_LANE_WRITE_SELECTS_N; // [R3]
		end else begin
			// Qualifier high and all-byte strobe high: a read
			next_we = `SBSP_WE_NONE; // [R15]
		end
	end

	// Outputs held off when deselected, on the first clock out of
	// deselect and through the data phase of a write
	always_comb begin
		next_block = 1'b0;
		if (next_sel == sbsp_pkg::SBSP_DESEL) begin
			next_block = 1'b1; // [R17]
		end else if (load && sel == sbsp_pkg::SBSP_DESEL) begin
			next_block = 1'b1; // [R13]
		end else if (next_we != `SBSP_WE_NONE) begin
			next_block = 1'b1; // [R17]
		end
	end

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// Caught while reset is held; the strap is meant to stay put,
	// so later wiggles on the pin are not followed
	always_ff @(posedge CLK) begin
		if (RST) begin
			order <= sbsp_pkg::sbsp_order_t'(BURST_ORDER_SEL); // [R16]
		end
	end

	// ------------------------------------------------------------
	// Selection and burst counter
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			sel  <= sbsp_pkg::SBSP_DESEL;
			base <= `SBSP_ADDR_RST;
			cnt  <= `SBSP_CNT_RST;
		end else if (CE) begin // [R5]
			sel  <= next_sel;
			base <= next_base;
			cnt  <= next_cnt;
		end
	end

	// ------------------------------------------------------------
	// Array address and write strobes
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			MEM_ADDR  <= `SBSP_ADDR_RST;
			MEM_WE    <= `SBSP_WE_NONE;
			MEM_WDATA <= `SBSP_DATA_RST;
		end else if (CE) begin
			MEM_ADDR  <= {next_base[`SBSP_ADDR_W-1:`SBSP_CNT_W],
				burst_low(order, next_base[`SBSP_CNT_W-1:0], next_cnt)}; // [R18]
			MEM_WE    <= next_we;
			MEM_WDATA <= DQ_IN; // [R5]
		end
	end

	// ------------------------------------------------------------
	// Data output path
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			drive_block <= 1'b1;
			DQ_OUT      <= `SBSP_DATA_RST;
		end else if (CE) begin
			drive_block <= next_block;
			DQ_OUT      <= MEM_RDATA;
		end
	end

	// The enable pin is not retimed: it must turn the pins around
	// within the cycle, so this is the one output not from a flop
	assign DQ_OE_N = OUTPUT_DRIVE_ENABLE_N | drive_block; // [R11] [R12]

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_LOAD_ADDR: // [R1]
		assert property (@(posedge CLK) disable iff (RST)
			CE && load && sel_now |=> MEM_ADDR == $past(ADDR_IN) && cnt == `SBSP_CNT_RST)
		else $error("Address not captured on a selected load");

	AST_SEED_LOW: // [R2]
		assert property (@(posedge CLK) disable iff (RST)
			CE && load && sel_now |=> MEM_ADDR[1:0] == $past(ADDR_IN[1:0]))
		else $error("Low address bits not seeded");

	AST_LANE_WRITE: // [R3]
		assert property (@(posedge CLK) disable iff (RST)
			CE && wr_cycle && ALL_BYTE_WRITE_STROBE_N |=>
			MEM_WE == ($past(BYTE_WRITE_QUALIFIER_N) ? `SBSP_WE_NONE :
				~$past(BYTE_LANE_WRITE_SELECTS_N)))
		else $error("Lane write strobes wrong");

	AST_ALL_WRITE: // [R4]
		assert property (@(posedge CLK) disable iff (RST)
			CE && wr_cycle && !ALL_BYTE_WRITE_STROBE_N |=> MEM_WE == `SBSP_WE_ALL)
		else $error("All-byte write missed a lane");

	AST_FREEZE: // [R5]
		assert property (@(posedge CLK) disable iff (RST)
			!CE |=> $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(sel))
		else $error("State moved with clock enable low");

	AST_BURST_STEP: // [R6]
		assert property (@(posedge CLK) disable iff (RST)
			CE && !load && sel == sbsp_pkg::SBSP_SEL && !BURST_ADVANCE_N |=>
			cnt == $past(cnt) + `SBSP_CNT_ONE)
		else $error("Burst counter did not step");

	AST_BURST_HOLD: // [R6]
		assert property (@(posedge CLK) disable iff (RST)
			CE && !load && BURST_ADVANCE_N |=> $stable(cnt) && $stable(MEM_ADDR))
		else $error("Burst address moved without advance");

	AST_STROBE_IGNORED: // [R7]
		assert property (@(posedge CLK) disable iff (RST)
			CE && !PROCESSOR_ADDRESS_STROBE_N && CHIP_SELECT_FIRST_LOW_N &&
			CONTROLLER_ADDRESS_STROBE_N && BURST_ADVANCE_N |=> $stable(MEM_ADDR))
		else $error("Processor strobe acted with first select high");

	AST_DESELECT: // [R8]
		assert property (@(posedge CLK) disable iff (RST)
			CE && load && !sel_now |=> sel == sbsp_pkg::SBSP_DESEL &&
			MEM_WE == `SBSP_WE_NONE)
		else $error("Device not deselected");

	AST_BALL_GRID: // [R10]
		assert property (@(posedge CLK) disable iff (RST)
			CE && load && BALL_GRID_PACKAGE && !CHIP_SELECT_FIRST_LOW_N &&
			CHIP_SELECT_SECOND_HIGH |=> sel == sbsp_pkg::SBSP_SEL)
		else $error("Third select not ignored on ball-grid variant");

	AST_SEL_HOLD: // [R9]
		assert property (@(posedge CLK) disable iff (RST)
			CE && !load |=> $stable(sel))
		else $error("Selection changed outside an address load");

	AST_FIRST_READ: // [R13]
		assert property (@(posedge CLK) disable iff (RST)
			CE && load && sel_now && sel == sbsp_pkg::SBSP_DESEL |=> DQ_OE_N)
		else $error("Pins driven on first clock after deselect");

	AST_PROC_WINS: // [R14]
		assert property (@(posedge CLK) disable iff (RST)
			CE && ps_take && !CONTROLLER_ADDRESS_STROBE_N |=> MEM_WE == `SBSP_WE_NONE)
		else $error("Controller strobe acted beside processor strobe");

	AST_DESEL_TRI: // [R17]
		assert property (@(posedge CLK) disable iff (RST)
			sel == sbsp_pkg::SBSP_DESEL || MEM_WE != `SBSP_WE_NONE |-> DQ_OE_N)
		else $error("Pins driven while deselected or writing");

	AST_LINEAR: // [R18]
		assert property (@(posedge CLK) disable iff (RST)
			CE && !load && sel == sbsp_pkg::SBSP_SEL && !BURST_ADVANCE_N &&
			order == sbsp_pkg::SBSP_LINEAR |=>
			MEM_ADDR[1:0] == $past(MEM_ADDR[1:0]) + `SBSP_CNT_ONE)
		else $error("Linear burst order wrong");

	AST_INTERLEAVE: // [R18]
		assert property (@(posedge CLK) disable iff (RST)
			CE && !load && sel == sbsp_pkg::SBSP_SEL &&
			order == sbsp_pkg::SBSP_INTERLEAVE |=>
			(MEM_ADDR[1:0] ^ $past(MEM_ADDR[1:0])) == (cnt ^ $past(cnt)))
		else $error("Interleaved burst order wrong");

endmodule // sbsp_port_ctrl

// file: tb/sbsp_mem_model.sv
// Behavioural memory array behind the port control
`timescale 1ns/1ns
`include "sbsp_defines.svh"
module sbsp_mem_model (
	// Clock
	input  wire logic                    clk,
	// Array port
	input  wire logic [`SBSP_ADDR_W-1:0] addr,
	input  wire logic [`SBSP_LANES-1:0]  we,
	input  wire logic [`SBSP_DATA_W-1:0] wdata,
	output logic      [`SBSP_DATA_W-1:0] rdata
);
	// Sixteen words only: higher addresses from the bench wrap onto them through addr[3:0]
	logic [`SBSP_DATA_W-1:0] mem [0:15];
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 36'h900000000 | 36'(i);
	end
	// Lane writes land at the address shown with the strobe
	always @(posedge clk) begin
		for (int i = 0; i < `SBSP_LANES; i++)
			if (we[i])
				mem[addr[3:0]][i*`SBSP_LANE_W +: `SBSP_LANE_W] <=
					wdata[i*`SBSP_LANE_W +: `SBSP_LANE_W];
	end
	assign rdata = mem[addr[3:0]];
endmodule // sbsp_mem_model

// file: tb/tb_sbsp_port_ctrl.sv
// Self-checking bench of the burst SRAM port control
`timescale 1ns/1ns
`include "sbsp_defines.svh"
module tb_sbsp_port_ctrl;
	logic                    clk, rst, ce, pas_n, cas_n, advance_n, cs1_n, cs2, cs3_n;
	logic                    ball_grid, bwq_n, all_wr_n, mode, oe_n, dq_oe_n, sel;
	logic [`SBSP_LANES-1:0]  bws_n, mem_we;
	logic [`SBSP_ADDR_W-1:0] addr, exp_a, mem_addr;
	logic [`SBSP_DATA_W-1:0] dq_in, dq_out, rdata, wdata;
	logic [3:0]              lanes [4];
	int                      err_count, checks_done;

	sbsp_port_ctrl u_sbsp_port_ctrl (.CLK(clk), .RST(rst), .CE(ce), .ADDR_IN(addr),
		.PROCESSOR_ADDRESS_STROBE_N(pas_n), .CONTROLLER_ADDRESS_STROBE_N(cas_n),
		.BURST_ADVANCE_N(advance_n), .CHIP_SELECT_FIRST_LOW_N(cs1_n),
		.CHIP_SELECT_SECOND_HIGH(cs2), .CHIP_SELECT_THIRD_LOW_N(cs3_n),
		.BALL_GRID_PACKAGE(ball_grid), .BYTE_LANE_WRITE_SELECTS_N(bws_n),
		.BYTE_WRITE_QUALIFIER_N(bwq_n), .ALL_BYTE_WRITE_STROBE_N(all_wr_n),
		.BURST_ORDER_SEL(mode), .OUTPUT_DRIVE_ENABLE_N(oe_n), .DQ_IN(dq_in),
		.DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .MEM_RDATA(rdata), .MEM_ADDR(mem_addr),
		.MEM_WE(mem_we), .MEM_WDATA(wdata));
	sbsp_mem_model u_sbsp_mem_model (.clk(clk), .addr(mem_addr), .we(mem_we),
		.wdata(wdata), .rdata(rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Strobes and selects {pas,cas,advance,cs1,cs2,cs3}, writes {all,qual}, lanes
	task cyc(input logic [5:0] s, input logic [19:0] a, input logic [1:0] w, input logic [3:0] l);
		@(negedge clk);
		{pas_n, cas_n, advance_n, cs1_n, cs2, cs3_n} = s;
		{all_wr_n, bwq_n} = w;
		bws_n = l;
		addr = a;
		dq_in = {16'hA5A5, a};
		@(posedge clk);
		#1;
	endtask

	task do_reset(input logic m);
		@(negedge clk);
		rst = 1'b1;
		mode = m;
		repeat (12) @(negedge clk);
		rst = 1'b0;
	endtask

	task burst(input logic m, input logic [19:0] a);
		do_reset(m);
		cyc(6'h2A, a, 2'h3, 4'hF);
		chk("burst_load", mem_addr, a);
		for (int i = 1; i < 4; i++) begin
			cyc(6'h35, 20'h00000, 2'h3, 4'hF);
			exp_a = {a[19:2], m ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
			chk("burst_step", mem_addr, exp_a);
		end
		cyc(6'h3D, 20'h00000, 2'h3, 4'hF);
		chk("burst_hold", mem_addr, exp_a);
		$display("test burst done");
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Tests need under a hundred cycles; twenty times that means a hang
	initial begin
		#20000;
		err_count++;
		conclude;
	end

	initial begin
		{rst, pas_n, cas_n, advance_n, cs1_n, cs2, cs3_n, ball_grid} = 8'hFD;
		{bwq_n, all_wr_n, mode, oe_n, bws_n, addr, dq_in} = '1;
		ce = 1'b1;
		lanes = '{4'hA, 4'h5, 4'hE, 4'h0};
		err_count = 0;
		checks_done = 0;
		do_reset(1'b0);
		chk("rst_addr", mem_addr, `SBSP_ADDR_RST);
		chk("rst_we", mem_we, `SBSP_WE_NONE);
		chk("rst_oe", dq_oe_n, 1'b1);
		chk("rst_dq", dq_out, `SBSP_DATA_RST);
		$display("test reset done");
		burst(1'b1, 20'h12355);
		burst(1'b0, 20'h12346);
		cyc(6'h2A, 20'h00200, 2'h3, 4'hF);
		exp_a = 20'h00200;
		for (int b = 0; b < 2; b++) begin
			@(negedge clk);
			ball_grid = 1'(b);
			for (int k = 0; k < 8; k++) begin
				sel = !k[2] && k[1] && (!k[0] || b[0]);
				cyc({3'h5, 3'(k)}, 20'h00100 + 20'(k), 2'h1, 4'hF);
				if (sel)
					exp_a = 20'h00100 + 20'(k);
				chk("sel_addr", mem_addr, exp_a);
				chk("sel_we", mem_we, sel ? 4'hF : 4'h0);
			end
		end
		cyc(6'h2A, 20'h00300, 2'h3, 4'hF);
		cyc(6'h1E, 20'h00304, 2'h3, 4'hF);
		chk("pas_cs1", mem_addr, 20'h00300);
		cyc(6'h0A, 20'h00308, 2'h1, 4'hF);
		chk("both_addr", mem_addr, 20'h00308);
		chk("both_we", mem_we, 4'h0);
		$display("test select done");
		foreach (lanes[j]) begin
			cyc(6'h2A, 20'h00040, 2'h2, lanes[j]);
			chk("lane_we", mem_we, lanes[j] ^ 4'hF);
			chk("lane_wd", wdata, {16'hA5A5, 20'h00040});
		end
		cyc(6'h2A, 20'h00040, 2'h3, 4'h0);
		chk("no_qual", mem_we, 4'h0);
		$display("test write done");
		// Clock enable low: a selected all-byte write must not land
		@(negedge clk);
		ce = 1'b0;
		cyc(6'h2A, 20'h00500, 2'h1, 4'hF);
		chk("frz_addr", mem_addr, 20'h00040);
		chk("frz_we", mem_we, 4'h0);
		$display("test freeze done");
		@(negedge clk);
		ce = 1'b1;
		oe_n = 1'b0;
		cyc(6'h2D, 20'h0000C, 2'h3, 4'hF);
		chk("oe_desel", dq_oe_n, 1'b1);
		cyc(6'h1A, 20'h0000C, 2'h3, 4'hF);
		chk("oe_first", dq_oe_n, 1'b1);
		cyc(6'h3D, 20'h0000C, 2'h3, 4'hF);
		chk("oe_read", dq_oe_n, 1'b0);
		chk("rd_data", dq_out, 36'h90000000C);
		// Enable changed between edges: pins must follow before the next rise
		@(negedge clk);
		oe_n = 1'b1;
		#1;
		chk("oe_async_off", dq_oe_n, 1'b1);
		@(negedge clk);
		oe_n = 1'b0;
		#1;
		chk("oe_async_on", dq_oe_n, 1'b0);
		cyc(6'h3D, 20'h0000C, 2'h1, 4'hF);
		chk("oe_write", dq_oe_n, 1'b1);
		$display("test drive done");
		conclude;
	end
endmodule // tb_sbsp_port_ctrl
